// file: conv_timing_ctrl.sv
/*
 Top of the converter timing control: sample clock divider, frame clock,
 over-range flag on the shared readback pin, alignment pulse qualification and
 multiframe alignment. Assumes the alignment pulse is asynchronous to clock_i.
*/
`timescale 1ns/100ps
// Operation
// - Sample rate equals input clock over divider 1, 2 or 4
// - Frame clock period equals sample period, one sample per frame
// - Core latency counted in frame cycles to multiframe boundary
// - Over-range flag rises 8 frame cycles after the bad sample
// - Flag releases after assert delay plus programmable 1 to 16 frames
// - Shared pin shows flag in flag mode unless readback is active, else only readback data
// - Multiframe aligns 4, 5 or 4.5 frames after accepted pulse
module conv_timing_ctrl #(
    parameter logic [7:0] MFRAME_LEN = conv_timing_pkg::MFRAME_LEN_RST
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [1:0] clock_divide_setting_i,
    input wire logic sample_overrange_i,
    input wire logic [3:0] release_extra_i,
    input wire logic flag_mode_i,
    input wire logic readback_active_i,
    input wire logic readback_data_i,
    input wire logic sysref_i,
    output logic frame_en_o,
    output logic [7:0] latency_count_o,
    output logic mframe_boundary_o,
    output logic sysref_accepted_o,
    output logic shared_readback_flag_pin_o,
    output logic shared_readback_flag_pin_oe_o
);
    if (MFRAME_LEN < 8'h08)
    begin : g_len_check
        $error("conv_timing_ctrl: MFRAME_LEN too small");
    end

    // Divider
    logic [1:0] div_cnt_r;
    logic [1:0] div_last;
    assign div_last = (clock_divide_setting_i == conv_timing_pkg::DIV_BY_4) ? 2'h3 :
                      (clock_divide_setting_i == conv_timing_pkg::DIV_BY_2) ? 2'h1 : 2'h0;
    wire logic frame_tick = (div_cnt_r >= div_last);

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            div_cnt_r <= 2'h0;
            frame_en_o <= 1'b0;
        end
        else
        begin
            div_cnt_r <= frame_tick ? 2'h0 : div_cnt_r + 2'h1;
            frame_en_o <= frame_tick;
        end
    end

    // Alignment pulse synchroniser and edge detect
    logic sys_s1_r;
    logic sys_s2_r;
    logic sys_prev_r;
    logic [1:0] high_cnt_r;
    logic [1:0] low_cnt_r;
    logic armed_r;
    wire logic rise = sys_s2_r & ~sys_prev_r;
    wire logic low_ok = (low_cnt_r >= 2'(conv_timing_pkg::SYSREF_MIN_LOW));
    wire logic high_ok = (high_cnt_r >= 2'(conv_timing_pkg::SYSREF_MIN_HIGH - 1));

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            sys_s1_r <= 1'b0;
            sys_s2_r <= 1'b0;
            sys_prev_r <= 1'b0;
            high_cnt_r <= 2'h0;
            low_cnt_r <= 2'h0;
            armed_r <= 1'b0;
        end
        else
        begin
            sys_s1_r <= sysref_i;
            sys_s2_r <= sys_s1_r;
            sys_prev_r <= sys_s2_r;
            if (rise)
                armed_r <= low_ok;
            // One acceptance per rising edge, not one per frame held high
            else if (!sys_s2_r || (frame_tick && high_ok))
                armed_r <= 1'b0;
            if (frame_tick)
            begin
                high_cnt_r <= !sys_s2_r ? 2'h0 : (high_cnt_r == 2'h3 ? high_cnt_r : high_cnt_r + 2'h1);
                low_cnt_r <= sys_s2_r ? 2'h0 : (low_cnt_r == 2'h3 ? low_cnt_r : low_cnt_r + 2'h1);
            end
            else if (rise)
                high_cnt_r <= 2'h0;
        end
    end

    // Accept once held high long enough
    wire logic accept = armed_r & sys_s2_r & frame_tick & high_ok;

    // Alignment delay in input clock cycles
    logic [4:0] align_dly;
    assign align_dly = (clock_divide_setting_i == conv_timing_pkg::DIV_BY_4) ? conv_timing_pkg::ALIGN_DLY_DIV4 :
                       (clock_divide_setting_i == conv_timing_pkg::DIV_BY_2) ? conv_timing_pkg::ALIGN_DLY_DIV2 :
                       conv_timing_pkg::ALIGN_DLY_DIV1;
    logic [4:0] align_cnt_r;
    logic align_busy_r;
    logic [7:0] mf_cnt_r;
    wire logic align_hit = align_busy_r & (align_cnt_r == 5'h01);

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            align_cnt_r <= 5'h00;
            align_busy_r <= 1'b0;
            mf_cnt_r <= 8'h00;
            sysref_accepted_o <= 1'b0;
            mframe_boundary_o <= 1'b0;
            latency_count_o <= 8'h00;
        end
        else
        begin
            sysref_accepted_o <= accept;
            if (accept & !align_busy_r)
            begin
                align_busy_r <= 1'b1;
                align_cnt_r <= align_dly;
            end
            else if (align_busy_r)
            begin
                align_cnt_r <= align_cnt_r - 5'h01;
                if (align_hit)
                    align_busy_r <= 1'b0;
            end
            // Boundary restarts on alignment, otherwise free runs in frames
            if (align_hit)
            begin
                mf_cnt_r <= 8'h00;
                mframe_boundary_o <= 1'b1;
            end
            else if (frame_tick)
            begin
                mf_cnt_r <= (mf_cnt_r == MFRAME_LEN - 8'h01) ? 8'h00 : mf_cnt_r + 8'h01;
                mframe_boundary_o <= (mf_cnt_r == MFRAME_LEN - 8'h01);
            end
            else
                mframe_boundary_o <= 1'b0;
            // Frames from a sample to the next boundary
            latency_count_o <= MFRAME_LEN - mf_cnt_r;
        end
    end

    // Over-range flag
    logic flag_w;
    flag_delay_line #(
        .DEPTH(24)
    ) u_flag (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .frame_en_i(frame_tick),
        .overrange_i(sample_overrange_i),
        .release_extra_i(release_extra_i),
        .overrange_flag_o(flag_w)
    );

    // Readback wins over the flag; pin idles high-Z otherwise
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            shared_readback_flag_pin_o <= 1'b0;
            shared_readback_flag_pin_oe_o <= 1'b0;
        end
        else
        begin
            shared_readback_flag_pin_oe_o <= readback_active_i | flag_mode_i;
            shared_readback_flag_pin_o <= readback_active_i ? readback_data_i : flag_w;
        end
    end

    property p_pin_quiet;
        @(posedge clock_i) disable iff (!resetn_i)
        (!readback_active_i && !flag_mode_i) |=> !shared_readback_flag_pin_oe_o;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("pin driven while idle");

    property p_frame_div;
        @(posedge clock_i) disable iff (!resetn_i)
        (frame_en_o && clock_divide_setting_i == conv_timing_pkg::DIV_BY_2 && $stable(clock_divide_setting_i))
        |=> !frame_en_o;
    endproperty
    a_frame_div: assert property (p_frame_div) else $error("frame enable too frequent");

    property p_accept_high;
        @(posedge clock_i) disable iff (!resetn_i)
        sysref_accepted_o |-> $past(sys_s2_r) && $past(sys_s2_r, 2);
    endproperty
    a_accept_high: assert property (p_accept_high) else $error("accept without high pulse");

    property p_align_div1;
        @(posedge clock_i) disable iff (!resetn_i)
        (accept && !align_busy_r && clock_divide_setting_i == conv_timing_pkg::DIV_BY_1)
        |-> ##5 mframe_boundary_o;
    endproperty
    a_align_div1: assert property (p_align_div1) else $error("alignment delay wrong");

    property p_pin_flag;
        @(posedge clock_i) disable iff (!resetn_i)
        (flag_mode_i && !readback_active_i) |=> shared_readback_flag_pin_o == $past(flag_w);
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("flag not on pin");

    property p_edge_after_low;
        @(posedge clock_i) disable iff (!resetn_i)
        (rise && !low_ok) |=> !armed_r;
    endproperty
    a_edge_after_low: assert property (p_edge_after_low) else $error("short low accepted");
endmodule : conv_timing_ctrl

// file: conv_timing_pkg.sv
/*
 Constants for the converter timing control: divider codes, flag latencies,
 alignment pulse qualification and multiframe alignment delays.
 Assumes a single 100 MHz core clock that stands for the input sample clock.
*/
package conv_timing_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Divider setting codes on clock_divide_setting_i
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    // Input clock ceilings per setting, MHz
    localparam int unsigned SAMPLE_CLOCK_INPUT_MAX_DIV1_MHZ = 500;
    localparam int unsigned SAMPLE_CLOCK_INPUT_MAX_DIV2_MHZ = 1000;
    localparam int unsigned SAMPLE_CLOCK_INPUT_MAX_DIV4_MHZ = 2000;
    localparam int unsigned FS_MIN_MSPS = 100;
    localparam int unsigned FS_MAX_MSPS = 500;
    // Latencies in frame clock cycles
    localparam int unsigned FLAG_ASSERT_LATENCY = 8;
    localparam int unsigned FLAG_RELEASE_EXTRA_MAX = 15;
    localparam int unsigned SYSREF_MIN_HIGH = 2;
    localparam int unsigned SYSREF_MIN_LOW = 2;
    // Alignment delay in input clock cycles (4, 5, 4.5 frame cycles)
    localparam logic [4:0] ALIGN_DLY_DIV1 = 5'h04;
    localparam logic [4:0] ALIGN_DLY_DIV2 = 5'h0a;
    localparam logic [4:0] ALIGN_DLY_DIV4 = 5'h12;
    localparam logic [7:0] MFRAME_LEN_RST = 8'h20;
endpackage : conv_timing_pkg

// file: flag_delay_line.sv
/*
 Over-range flag timing: fixed assert latency, programmable release latency.
 Assumes frame_en_i pulses once per frame clock cycle.
*/
`timescale 1ns/100ps
module flag_delay_line #(
    parameter int unsigned DEPTH = 24
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic frame_en_i,
    input wire logic overrange_i,
    input wire logic [3:0] release_extra_i,
    output logic overrange_flag_o
);
    logic [DEPTH-1:0] hist_r;
    logic [4:0] hold_r;
    wire logic assert_tap = hist_r[conv_timing_pkg::FLAG_ASSERT_LATENCY-1];
    wire logic [4:0] release_len = 5'(release_extra_i) + 5'h01;

    // Refused at elaboration: history must span assert plus longest release
    if (DEPTH < conv_timing_pkg::FLAG_ASSERT_LATENCY + conv_timing_pkg::FLAG_RELEASE_EXTRA_MAX)
    begin : g_depth_check
        $error("flag_delay_line: DEPTH too small");
    end

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            hist_r <= '0;
            hold_r <= 5'h00;
            overrange_flag_o <= 1'b0;
        end
        else if (frame_en_i)
        begin
            hist_r <= {hist_r[DEPTH-2:0], overrange_i};
            // Stretch after the last out-of-range sample reaches the tap
            if (assert_tap)
            begin
                overrange_flag_o <= 1'b1;
                hold_r <= release_len;
            end
            else if (hold_r > 5'h01)
                hold_r <= hold_r - 5'h01;
            else
            begin
                hold_r <= 5'h00;
                overrange_flag_o <= 1'b0;
            end
        end
    end
endmodule : flag_delay_line

// file: sysref_source.sv
/*
 Behavioural model of the external clock source that drives the alignment pulse.
 Assumes the caller enters send just after a rising edge of clock_i.
*/
`timescale 1ns/100ps
module sysref_source (
    input wire logic clock_i,
    output logic sysref_o
);
    initial sysref_o = 1'b0;

    // Low phase, then high phase, then left low and driven, never floated
    task automatic send(input int low_clocks, input int high_clocks);
        repeat (low_clocks) @(posedge clock_i);
        #1;
        sysref_o = 1'b1;
        repeat (high_clocks) @(posedge clock_i);
        #1;
        sysref_o = 1'b0;
    endtask : send
endmodule : sysref_source

// file: testbench.sv
/*
 Self-checking testbench for the converter timing control top.
 Assumes one 100 MHz clock and the sysref_source model on the alignment input.
*/
`timescale 1ns/100ps
module testbench;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [1:0] div = conv_timing_pkg::DIV_BY_1;
    logic overrange_flag = 1'b0;
    logic [3:0] extra = 4'h0;
    logic mode = 1'b0;
    logic rb_act = 1'b0;
    logic rb_data = 1'b0;
    logic sysref;
    logic frame_en;
    logic mb;
    logic acc;
    logic pin;
    logic oe;
    logic [7:0] lat;
    int n_errors = 0;
    int checks_done = 0;

    always #(conv_timing_pkg::CLK_PERIOD_NS / 2.0) clock_i = ~clock_i;

    conv_timing_ctrl #(.MFRAME_LEN(8'h20)) DUT (
        .clock_i(clock_i), .resetn_i(resetn_i), .clock_divide_setting_i(div),
        .sample_overrange_i(overrange_flag), .release_extra_i(extra), .flag_mode_i(mode),
        .readback_active_i(rb_act), .readback_data_i(rb_data), .sysref_i(sysref),
        .frame_en_o(frame_en), .latency_count_o(lat), .mframe_boundary_o(mb),
        .sysref_accepted_o(acc), .shared_readback_flag_pin_o(pin), .shared_readback_flag_pin_oe_o(oe)
    );

    sysref_source src (.clock_i(clock_i), .sysref_o(sysref));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check

    // Inputs always move 1 ns after the edge, away from sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    // Divider is static, so it only changes under reset
    task automatic do_reset(input logic [1:0] d);
        resetn_i = 1'b0;
        div = d;
        tick(8);
        resetn_i = 1'b1;
        tick(2);
    endtask : do_reset

    task automatic test_divider;
        int n;
        for (int i = 0; i < 3; i++)
        begin
            do_reset(i[1:0]);
            n = 0;
            repeat (40)
            begin
                tick(1);
                n += int'(frame_en === 1'b1);
            end
            check("frame_en count", 40 >> i, n);
        end
        $display("test divider done");
    endtask : test_divider

    task automatic test_flag(input logic [3:0] x);
        int t;
        int w;
        extra = x;
        mode = 1'b1;
        tick(4);
        check("pin enable in flag mode", 1, oe);
        overrange_flag = 1'b1;
        tick(1);
        overrange_flag = 1'b0;
        t = 1;
        while (pin !== 1'b1 && t < 30)
        begin
            tick(1);
            t++;
        end
        check("flag assert latency in 8..10", 1, t >= 8 && t <= 10);
        w = 0;
        while (pin === 1'b1 && w < 40)
        begin
            tick(1);
            w++;
        end
        check("flag high width", x + 1, w);
        mode = 1'b0;
        tick(3);
        check("pin enable idle", 0, oe);
        rb_act = 1'b1;
        rb_data = 1'b1;
        tick(3);
        check("pin enable readback", 1, oe);
        check("pin readback one", 1, pin);
        rb_data = 1'b0;
        tick(2);
        check("pin readback zero", 0, pin);
        rb_act = 1'b0;
        $display("test flag done");
    endtask : test_flag

    task automatic test_sysref(input logic [1:0] d, input int fd, input int dly);
        int t;
        do_reset(d);
        fork
            src.send(4 * fd, 3 * fd);
            begin
                t = 0;
                while (acc !== 1'b1 && t < 60)
                begin
                    tick(1);
                    t++;
                end
                check("alignment pulse accepted", 1, acc);
                t = 0;
                while (mb !== 1'b1 && t < 40)
                begin
                    tick(1);
                    t++;
                end
                check("alignment delay clocks", dly, t);
                // Sample right after a boundary waits a whole multiframe
                tick(1);
                check("latency count after boundary", conv_timing_pkg::MFRAME_LEN_RST, lat);
            end
        join
        tick(20);
        $display("test sysref done");
    endtask : test_sysref

    // Second pulse follows a one-clock low gap and must be ignored
    task automatic test_short_low;
        int n;
        do_reset(conv_timing_pkg::DIV_BY_1);
        n = 0;
        fork
            begin
                src.send(4, 6);
                src.send(1, 4);
            end
            repeat (40)
            begin
                tick(1);
                n += int'(acc === 1'b1);
            end
        join
        check("accepts with short low gap", 1, n);
        $display("test short low done");
    endtask : test_short_low

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    initial
    begin
        test_divider();
        do_reset(conv_timing_pkg::DIV_BY_1);
        test_flag(4'h0);
        test_flag(4'hf);
        test_sysref(conv_timing_pkg::DIV_BY_1, 1, int'(conv_timing_pkg::ALIGN_DLY_DIV1));
        test_sysref(conv_timing_pkg::DIV_BY_2, 2, int'(conv_timing_pkg::ALIGN_DLY_DIV2));
        test_sysref(conv_timing_pkg::DIV_BY_4, 4, int'(conv_timing_pkg::ALIGN_DLY_DIV4));
        test_short_low();
        test_done();
    end

    // Tests need well under 2000 cycles
    initial
    begin
        #(20000 * conv_timing_pkg::CLK_PERIOD_NS);
        n_errors++;
        $display("ERROR watchdog expected done seen timeout");
        test_done();
    end
endmodule : testbench
